/* logic/smb_pkg.sv */
package smb_pkg;

    // Widths of the external bus and of the burst bookkeeping
    localparam int ADDR_W   = 28;
    localparam int DATA_W   = 32;
    localparam int BEATS    = 4;
    localparam int BEAT_W   = 2;
    localparam int LEN_W    = 3;
    localparam int WAIT_W   = 4;
    localparam int CNT_W    = 5;

    // Burst length limits in accesses
    localparam logic [LEN_W-1:0] LEN_MIN = 3'h2;
    localparam logic [LEN_W-1:0] LEN_MAX = 3'h4;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFF_CONFIG  = 8'h00;
    localparam logic [7:0] OFF_ADDRESS = 8'h04;
    localparam logic [7:0] OFF_COMMAND = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0C;
    localparam logic [7:0] OFF_WDATA0  = 8'h10;
    localparam logic [7:0] OFF_RDATA0  = 8'h20;

    // Configuration register fields
    localparam int CFG_LEN_LSB   = 0;
    localparam int CFG_WAIT_LSB  = 4;
    localparam int CFG_SEQW_LSB  = 8;
    localparam int CFG_SEQEN_BIT = 12;
    localparam logic [31:0] CFG_MASK  = 32'h0000_1FF7;
    localparam logic [31:0] CFG_RESET = 32'h0000_1004;

    // Command register fields
    localparam int CMD_START_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_HALF_BIT  = 2;
    localparam int CMD_WORD_BIT  = 3;

    // Status register fields
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_DONE_BIT = 1;
    localparam int STS_LEN_LSB  = 4;

    // Access timing: the first access and every write carry one wait more
    localparam logic [CNT_W-1:0] EXTRA_WAIT = 5'h01;

    // Address steps per access size
    localparam logic [ADDR_W-1:0] STEP_BYTE = 28'h0000001;
    localparam logic [ADDR_W-1:0] STEP_HALF = 28'h0000002;
    localparam logic [ADDR_W-1:0] STEP_WORD = 28'h0000004;

    // Link sequencer states
    typedef enum logic [1:0] {
        S_IDLE,
        S_WAIT,
        S_CHECK,
        S_GAP
    } smb_state_t;

endpackage

/* logic/smb_toggle_sync.sv */
`timescale 1ns/1ps
module smb_toggle_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic toggle_i,
    output logic      pulse_o
);

    logic meta;
    logic stage2;
    logic stage3;

    // Two flops settle the toggle, the third gives the edge reference
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta   <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            meta   <= toggle_i;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    // One pulse per toggle, meta stays out of the compare
    assign pulse_o = stage2 ^ stage3;

endmodule

/* logic/smb_ready_sampler.sv */
`timescale 1ns/1ps
module smb_ready_sampler (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ready_i,
    output logic      ready_o
);

    logic meta;
    logic stage2;
    logic stage3;

    // Sampled on the falling edge so the answer is ready for the next rising edge
    always_ff @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta    <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            meta   <= ready_i;
            stage2 <= meta;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                ready_o <= stage3;
            end
        end
    end

endmodule

/* logic/smb_burst_ctrl.sv */
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module smb_burst_ctrl (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        expansion_clock_i,
    input  wire logic        expansion_ready_i,
    input  wire logic [31:0] mem_data_i,
    output logic      [31:0] mem_data_o,
    output logic             mem_data_oe_n_o,
    output logic      [27:0] mem_address_o,
    output logic             mem_halfword_o,
    output logic             mem_word_o,
    output logic             mem_write_o,
    output logic             mem_select_n_o,
    output logic             mem_read_strobe_n_o,
    output logic             memory_write_strobe_n_o
);

    // Core side state
    logic [31:0]               cfg;
    logic [smb_pkg::ADDR_W-1:0] start_addr;
    logic [31:0]               wdata [smb_pkg::BEATS];
    logic [31:0]               rdata [smb_pkg::BEATS];
    logic [31:0]               cmd_cfg;
    logic [smb_pkg::ADDR_W-1:0] cmd_addr;
    logic                      cmd_write;
    logic                      cmd_half;
    logic                      cmd_word;
    logic                      busy;
    logic                      done_flag;
    logic                      req_tgl;
    logic                      done_pulse;
    logic                      wr_en;
    logic                      start;
    logic [7:0]                word_adr;
    logic [31:0]               next_rd;

    // Link side state
    logic                      rst_meta;
    logic                      link_rst;
    smb_pkg::smb_state_t       state;
    smb_pkg::smb_state_t       next_state;
    logic [smb_pkg::CNT_W-1:0] wcnt;
    logic [smb_pkg::BEAT_W-1:0] beat;
    logic [smb_pkg::BEAT_W-1:0] load_beat;
    logic [31:0]               rbuf [smb_pkg::BEATS];
    logic                      done_tgl;
    logic                      req_pulse;
    logic                      rdy_ok;
    logic [smb_pkg::LEN_W-1:0] eff_len;
    logic [smb_pkg::WAIT_W-1:0] wait_norm;
    logic [smb_pkg::WAIT_W-1:0] wait_seq;
    logic                      seq_en;
    logic [smb_pkg::CNT_W-1:0] first_wait;
    logic [smb_pkg::CNT_W-1:0] follow_wait;
    logic [smb_pkg::CNT_W-1:0] load_wait;
    logic [smb_pkg::ADDR_W-1:0] step;
    logic                      start_seen;
    logic                      xfer;
    logic                      last;
    logic                      load;

    // Byte-lane merge for Wishbone writes
    function automatic logic [31:0] smb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Out-of-range lengths are pulled into the legal window
    function automatic logic [smb_pkg::LEN_W-1:0] smb_clamp(input logic [smb_pkg::LEN_W-1:0] len);
        logic [smb_pkg::LEN_W-1:0] r;
        r = len;
        if (len < smb_pkg::LEN_MIN) begin
            r = smb_pkg::LEN_MIN;
        end else if (len > smb_pkg::LEN_MAX) begin
            r = smb_pkg::LEN_MAX;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Core clock domain: Wishbone slave and command handshake
    // ------------------------------------------------------------------

    assign word_adr = {wb_adr_i[7:2], 2'b00};
    assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign start    = wr_en & (word_adr == smb_pkg::OFF_COMMAND) & wb_sel_i[0]
                    & wb_dat_i[smb_pkg::CMD_START_BIT] & ~busy;

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    // Read mux; unmapped offsets answer zero
    always_comb begin
        next_rd = 32'h0000_0000;
        if (word_adr == smb_pkg::OFF_CONFIG) begin
            next_rd = cfg;
        end else if (word_adr == smb_pkg::OFF_ADDRESS) begin
            next_rd = {4'h0, start_addr};
        end else if (word_adr == smb_pkg::OFF_COMMAND) begin
            next_rd[smb_pkg::CMD_WRITE_BIT] = cmd_write;
            next_rd[smb_pkg::CMD_HALF_BIT]  = cmd_half;
            next_rd[smb_pkg::CMD_WORD_BIT]  = cmd_word;
        end else if (word_adr == smb_pkg::OFF_STATUS) begin
            next_rd[smb_pkg::STS_BUSY_BIT] = busy;
            next_rd[smb_pkg::STS_DONE_BIT] = done_flag;
            next_rd[smb_pkg::STS_LEN_LSB +: smb_pkg::LEN_W] =
                smb_clamp(cfg[smb_pkg::CFG_LEN_LSB +: smb_pkg::LEN_W]);
        end else if (wb_adr_i[7:4] == smb_pkg::OFF_WDATA0[7:4]) begin
            next_rd = wdata[wb_adr_i[3:2]];
        end else if (wb_adr_i[7:4] == smb_pkg::OFF_RDATA0[7:4]) begin
            next_rd = rdata[wb_adr_i[3:2]];
        end
    end

    // Read data is registered together with the ack
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
            wb_dat_o <= next_rd;
        end
    end

    // Configuration and start address
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg        <= smb_pkg::CFG_RESET;
            start_addr <= 28'h0000000;
        end else if (wr_en) begin
            if (word_adr == smb_pkg::OFF_CONFIG) begin
                cfg <= smb_merge(cfg, wb_dat_i, wb_sel_i) & smb_pkg::CFG_MASK;
            end
            if (word_adr == smb_pkg::OFF_ADDRESS) begin
                start_addr <= smb_pkg::ADDR_W'(
                    smb_merge({4'h0, start_addr}, wb_dat_i, wb_sel_i));
            end
        end
    end

    // Write data is locked while busy, the link reads it mid-burst
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < smb_pkg::BEATS; i++) begin
                wdata[i] <= 32'h0000_0000;
            end
        end else if (wr_en & ~busy & (wb_adr_i[7:4] == smb_pkg::OFF_WDATA0[7:4])) begin
            wdata[wb_adr_i[3:2]] <= smb_merge(wdata[wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
        end
    end

    // Snapshot of the burst; stays stable until the link reports done
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmd_cfg   <= smb_pkg::CFG_RESET;
            cmd_addr  <= 28'h0000000;
            cmd_write <= 1'b0;
            cmd_half  <= 1'b0;
            cmd_word  <= 1'b0;
            req_tgl   <= 1'b0;
        end else if (start) begin
            cmd_cfg   <= cfg;
            cmd_addr  <= start_addr;
            cmd_write <= wb_dat_i[smb_pkg::CMD_WRITE_BIT];
            cmd_half  <= wb_dat_i[smb_pkg::CMD_HALF_BIT];
            cmd_word  <= wb_dat_i[smb_pkg::CMD_WORD_BIT];
            req_tgl   <= ~req_tgl;
        end
    end

    // Busy and sticky done; a done arriving with a clear still sets
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy      <= 1'b0;
            done_flag <= 1'b0;
        end else begin
            if (start) begin
                busy <= 1'b1;
            end else if (done_pulse) begin
                busy <= 1'b0;
            end
            if (done_pulse) begin
                done_flag <= 1'b1;
            end else if (wr_en & (word_adr == smb_pkg::OFF_STATUS) & wb_sel_i[0]
                         & wb_dat_i[smb_pkg::STS_DONE_BIT]) begin
                done_flag <= 1'b0;
            end
        end
    end

    // Read data copied home once the burst is over; the link keeps it still meanwhile
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < smb_pkg::BEATS; i++) begin
                rdata[i] <= 32'h0000_0000;
            end
        end else if (done_pulse & ~cmd_write) begin
            for (int i = 0; i < smb_pkg::BEATS; i++) begin
                rdata[i] <= rbuf[i];
            end
        end
    end

    smb_toggle_sync u_done_sync (
        .clk_i    (core_clk_i),
        .rst_i    (reset_i),
        .toggle_i (done_tgl),
        .pulse_o  (done_pulse)
    );

    // ------------------------------------------------------------------
    // Link clock domain: burst sequencer on the expansion clock
    // ------------------------------------------------------------------

    // Reset asserts at once but releases in step with the link clock
    always_ff @(posedge expansion_clock_i or posedge reset_i) begin
        if (reset_i) begin
            rst_meta <= 1'b1;
            link_rst <= 1'b1;
        end else begin
            rst_meta <= 1'b0;
            link_rst <= rst_meta;
        end
    end

    smb_toggle_sync u_req_sync (
        .clk_i    (expansion_clock_i),
        .rst_i    (link_rst),
        .toggle_i (req_tgl),
        .pulse_o  (req_pulse)
    );

    smb_ready_sampler u_ready (
        .clk_i    (expansion_clock_i),
        .rst_i    (link_rst),
        .ready_i  (expansion_ready_i),
        .ready_o  (rdy_ok)
    );

    // Burst parameters, held still by the core while busy
    assign eff_len   = smb_clamp(cmd_cfg[smb_pkg::CFG_LEN_LSB +: smb_pkg::LEN_W]);
    assign wait_norm = cmd_cfg[smb_pkg::CFG_WAIT_LSB +: smb_pkg::WAIT_W];
    assign wait_seq  = cmd_cfg[smb_pkg::CFG_SEQW_LSB +: smb_pkg::WAIT_W];
    assign seq_en    = cmd_cfg[smb_pkg::CFG_SEQEN_BIT];
    assign step      = cmd_word ? smb_pkg::STEP_WORD : (cmd_half ? smb_pkg::STEP_HALF : smb_pkg::STEP_BYTE);

    // First access always carries one extra wait; writes carry it on every access
    assign first_wait  = {1'b0, wait_norm} + smb_pkg::EXTRA_WAIT;
    assign follow_wait = {1'b0, (seq_en ? wait_seq : wait_norm)}
                       + (cmd_write ? smb_pkg::EXTRA_WAIT : 5'h00);

    // Sequencing events
    assign start_seen = (state == smb_pkg::S_IDLE) & req_pulse;
    assign xfer       = (state == smb_pkg::S_CHECK) & rdy_ok;
    assign last       = ({1'b0, beat} == (eff_len - 3'h1));
    assign load       = start_seen | (xfer & ~last & seq_en) | (state == smb_pkg::S_GAP);
    assign load_wait  = start_seen ? first_wait : follow_wait;
    assign load_beat  = start_seen ? 2'h0 : beat + 2'h1;

    // Next state: waits first, then ready checks, then idle gap if not sequential
    always_comb begin
        next_state = state;
        unique case (state)
            smb_pkg::S_IDLE: begin
                if (req_pulse) begin
                    next_state = (load_wait == 5'h00) ? smb_pkg::S_CHECK : smb_pkg::S_WAIT;
                end
            end
            smb_pkg::S_WAIT: begin
                if (wcnt == 5'h01) begin
                    next_state = smb_pkg::S_CHECK;
                end
            end
            smb_pkg::S_CHECK: begin
                if (xfer & last) begin
                    next_state = smb_pkg::S_IDLE;
                end else if (xfer & seq_en) begin
                    next_state = (load_wait == 5'h00) ? smb_pkg::S_CHECK : smb_pkg::S_WAIT;
                end else if (xfer) begin
                    next_state = smb_pkg::S_GAP;
                end
            end
            smb_pkg::S_GAP: begin
                next_state = (load_wait == 5'h00) ? smb_pkg::S_CHECK : smb_pkg::S_WAIT;
            end
        endcase
    end

    // State, wait counter and beat index; every stall is whole link periods
    always_ff @(posedge expansion_clock_i or posedge link_rst) begin
        if (link_rst) begin
            state <= smb_pkg::S_IDLE;
            wcnt  <= 5'h00;
            beat  <= 2'h0;
        end else begin
            state <= next_state;
            if (load) begin
                wcnt <= load_wait;
                beat <= load_beat;
            end else if (state == smb_pkg::S_WAIT) begin
                wcnt <= wcnt - 5'h01;
            end
        end
    end

    // Address, data and size only change when the next access begins
    always_ff @(posedge expansion_clock_i or posedge link_rst) begin
        if (link_rst) begin
            mem_address_o   <= 28'h0000000;
            mem_data_o      <= 32'h0000_0000;
            mem_data_oe_n_o <= 1'b1;
            mem_halfword_o  <= 1'b0;
            mem_word_o      <= 1'b0;
            mem_write_o     <= 1'b0;
        end else if (start_seen) begin
            mem_address_o   <= cmd_addr;
            mem_data_o      <= wdata[0];
            mem_data_oe_n_o <= ~cmd_write;
            mem_halfword_o  <= cmd_half;
            mem_word_o      <= cmd_word;
            mem_write_o     <= cmd_write;
        end else if (load) begin
            mem_address_o <= mem_address_o + step;
            mem_data_o    <= wdata[load_beat];
        end
    end

    // Select and strobes follow the coming state; write strobe only after the waits
    always_ff @(posedge expansion_clock_i or posedge link_rst) begin
        if (link_rst) begin
            mem_select_n_o          <= 1'b1;
            mem_read_strobe_n_o     <= 1'b1;
            memory_write_strobe_n_o <= 1'b1;
        end else begin
            mem_select_n_o <= (next_state == smb_pkg::S_IDLE) | (next_state == smb_pkg::S_GAP);
            mem_read_strobe_n_o <= ~(~cmd_write & ((next_state == smb_pkg::S_WAIT)
                                                 | (next_state == smb_pkg::S_CHECK)));
            memory_write_strobe_n_o <= ~(cmd_write & (next_state == smb_pkg::S_CHECK));
        end
    end

    // Read capture and completion toggle
    always_ff @(posedge expansion_clock_i or posedge link_rst) begin
        if (link_rst) begin
            for (int i = 0; i < smb_pkg::BEATS; i++) begin
                rbuf[i] <= 32'h0000_0000;
            end
            done_tgl <= 1'b0;
        end else if (xfer) begin
            if (~cmd_write) begin
                rbuf[beat] <= mem_data_i;
            end
            if (last) begin
                done_tgl <= ~done_tgl;
            end
        end
    end

endmodule

/* dv/smb_checker.sv */
`timescale 1ns/1ps
// Watches the link pins and the register bus handshake of the burst block
module smb_checker (
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        expansion_clock_i,
    input wire logic        expansion_ready_i,
    input wire logic [31:0] mem_data_o,
    input wire logic        mem_data_oe_n_o,
    input wire logic [27:0] mem_address_o,
    input wire logic        mem_write_o,
    input wire logic        mem_select_n_o,
    input wire logic        mem_read_strobe_n_o,
    input wire logic        memory_write_strobe_n_o
);
    // Steps of an access as seen from the pins
    sequence s_idle;
        mem_select_n_o && $past(mem_select_n_o);
    endsequence
    sequence s_start;
        $fell(mem_select_n_o);
    endsequence
    // Five low samples outlast the ready filter, so no transfer may end the check phase
    sequence s_held_low;
        (!memory_write_strobe_n_o && !expansion_ready_i) [*5];
    endsequence

    a_addr_hold: assert property (@(posedge expansion_clock_i) disable iff (reset_i)
        s_idle |-> $stable(mem_address_o) && $stable(mem_write_o)) else $error("address moved while idle");
    a_data_hold: assert property (@(posedge expansion_clock_i) disable iff (reset_i)
        s_idle and mem_write_o |-> $stable(mem_data_o)) else $error("write data moved while idle");
    a_first_wait: assert property (@(posedge expansion_clock_i) disable iff (reset_i)
        s_start |-> memory_write_strobe_n_o) else $error("access began without its wait state");
    a_stall_hold: assert property (@(posedge expansion_clock_i) disable iff (reset_i)
        s_held_low |=> !memory_write_strobe_n_o) else $error("transfer ended while ready was low");
    a_wstrobe_qual: assert property (@(posedge expansion_clock_i) disable iff (reset_i)
        !memory_write_strobe_n_o |-> mem_write_o && !mem_select_n_o && !mem_data_oe_n_o)
        else $error("write strobe outside a driven write access");
    a_rstrobe_qual: assert property (@(posedge expansion_clock_i) disable iff (reset_i)
        !mem_read_strobe_n_o |-> !mem_write_o && !mem_select_n_o) else $error("read strobe outside a read");
    a_ack_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked next cycle");
endmodule

bind smb_burst_ctrl smb_checker chk_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .expansion_clock_i(expansion_clock_i),
    .expansion_ready_i(expansion_ready_i), .mem_data_o(mem_data_o), .mem_data_oe_n_o(mem_data_oe_n_o),
    .mem_address_o(mem_address_o), .mem_write_o(mem_write_o), .mem_select_n_o(mem_select_n_o),
    .mem_read_strobe_n_o(mem_read_strobe_n_o), .memory_write_strobe_n_o(memory_write_strobe_n_o));

/* dv/smb_mem_model.sv */
`timescale 1ns/1ps
// Static memory on the burst port; reads return a pattern built from the address
module smb_mem_model (
    input wire logic        clk_i,
    input wire logic        stall_i,
    input wire logic [27:0] address_i,
    input wire logic [31:0] data_i,
    input wire logic        select_n_i,
    input wire logic        read_strobe_n_i,
    input wire logic        write_strobe_n_i,
    output logic            ready_o,
    output logic     [31:0] data_o
);
    logic [31:0] junk = 32'h5A5A5A5A;
    logic [31:0] wmem [logic [27:0]];
    logic [27:0] addr_q [$];
    int          sel_cnt = 0;
    int          first_e = 0;
    int          last_e = 0;
    int          edge_n = 0;

    initial ready_o = 1'b1;
    // Ready moves a few ns after the request, with no regard to the link clock
    always @(stall_i) #3 ready_o = !stall_i;
    // A released bus shows a value that flips every cycle, never the last data
    assign data_o = !read_strobe_n_i ? {4'hA, address_i} : junk;
    // Count selected cycles and note each new address and written word
    always @(posedge clk_i) begin
        junk <= ~junk;
        edge_n <= edge_n + 1;
        if (!select_n_i) begin
            if (sel_cnt == 0) first_e <= edge_n;
            last_e <= edge_n;
            sel_cnt <= sel_cnt + 1;
            if (addr_q.size() == 0 || addr_q[$] != address_i) addr_q.push_back(address_i);
        end
        if (!write_strobe_n_i) wmem[address_i] = data_i;
    end
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
    logic        core_clk_i = 1'b0;
    logic        link_clk = 1'b0;
    logic        reset_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic        stall = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] rdat, wb_q, mem_in, mem_out;
    logic [27:0] maddr;
    logic        ack, oe_n, half, word, wr, sel_n, rd_n, wr_n, rdy;
    logic [31:0] lfsr = 32'hD097149D;
    logic [31:0] wd [4];
    int          fail_count = 0;
    int          n_checks = 0;
    int          cycles = 0;

    always #2.5 core_clk_i = ~core_clk_i;
    // Link clock offset so its edges never line up with the core clock
    initial begin
        #7.3;
        forever #15 link_clk = ~link_clk;
    end

    smb_burst_ctrl dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .expansion_clock_i(link_clk), .expansion_ready_i(rdy), .mem_data_i(mem_in), .mem_data_o(mem_out),
        .mem_data_oe_n_o(oe_n), .mem_address_o(maddr), .mem_halfword_o(half), .mem_word_o(word),
        .mem_write_o(wr), .mem_select_n_o(sel_n), .mem_read_strobe_n_o(rd_n), .memory_write_strobe_n_o(wr_n));
    smb_mem_model pm_u (.clk_i(link_clk), .stall_i(stall), .address_i(maddr), .data_i(mem_out),
        .select_n_i(sel_n), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .ready_o(rdy), .data_o(mem_in));

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Classic single cycle: hold the request until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        dat <= d;
        do @(posedge core_clk_i); while (ack !== 1'b1);
        wb_q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // One burst end to end; cycle counts assume ready high unless the stall is used
    task automatic burst(input logic w, input int len, input int nw, input int sq, input logic sen,
                         input logic [1:0] sz, input logic hold);
        int          n;
        int          step;
        int          e;
        logic [27:0] a;
        n = (len < 2) ? 2 : (len > 4) ? 4 : len;
        step = sz[1] ? 4 : sz[0] ? 2 : 1;
        lfsr = nxt(lfsr);
        a = {lfsr[27:4], 4'h0};
        wb(1'b1, 8'h00, {19'h0, sen, sq[3:0], nw[3:0], 1'b0, len[2:0]});
        wb(1'b1, 8'h04, {4'h0, a});
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            wd[k] = lfsr;
            wb(1'b1, 8'h10 + 8'(4 * k), lfsr);
        end
        pm_u.sel_cnt = 0;
        pm_u.addr_q.delete();
        stall <= hold;
        wb(1'b1, 8'h08, {28'h0, sz, w, 1'b1});
        if (hold) repeat (100) @(posedge core_clk_i);
        stall <= 1'b0;
        do wb(1'b0, 8'h0C, 32'h0); while (wb_q[1] !== 1'b1);
        `CHK(wb_q[6:4], 3'(n))
        wb(1'b1, 8'h0C, 32'h2);
        `CHK(pm_u.addr_q.size(), n)
        for (int k = 0; k < n; k++) begin
            `CHK(pm_u.addr_q[k], a + 28'(k * step))
            if (w) begin
                `CHK(pm_u.wmem[a + 28'(k * step)], wd[k])
            end else begin
                wb(1'b0, 8'h20 + 8'(4 * k), 32'h0);
                `CHK(wb_q, {4'hA, a + 28'(k * step)})
            end
        end
        // First access carries one wait more; writes carry one on every access
        e = nw + 2 + ((sen ? sq : nw) + 1 + int'(w)) * (n - 1);
        if (hold) `CHK(pm_u.sel_cnt > e, 1'b1)
        else `CHK(pm_u.sel_cnt, e)
        `CHK(pm_u.last_e - pm_u.first_e + 1 - pm_u.sel_cnt, sen ? 0 : n - 1)
        `CHK({word, half, wr}, {sz, w})
        $display("burst done write=%0d beats=%0d", w, n);
    endtask

    // A hang ends here with a mismatch counted
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (30) @(posedge core_clk_i);
        wb(1'b0, 8'h00, 32'h0);
        `CHK(wb_q, 32'h00001004)
        wb(1'b0, 8'h40, 32'h0);
        `CHK(wb_q, 32'h00000000)
        $display("register checks done");
        for (int l = 0; l < 8; l++) burst(1'b0, l, 0, 0, 1'b1, 2'b10, 1'b0);
        for (int l = 2; l < 5; l++) burst(1'b1, l, 0, 0, 1'b0, 2'b01, 1'b0);
        burst(1'b0, 3, 2, 1, 1'b1, 2'b00, 1'b0);
        burst(1'b1, 4, 1, 2, 1'b1, 2'b10, 1'b1);
        print_verdict();
    end
endmodule
